// *** src/card_bridge_system_control.sv ***
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module card_bridge_system_control
    import sysctl_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Bridge events
    input  wire logic        power_write_i,
    input  wire logic        card_dma_req_i,
    input  wire logic        cardbus_present_i,
    // Controls
    output logic [1:0]       irq_serial_slot_step_o,
    output logic             internal_osc_enable_o,
    output logic             power_irq2_o,
    output logic             card_status_change_o,
    output logic             reserved_pin_drive_low_o,
    output logic             reserved_pin_oe_o,
    output logic             supply_protect_enable_o,
    output logic             upper_addr_float_o,
    output logic             dma_request_o,
    output logic [2:0]       dma_channel_select_o,
    output logic             down_read_burst_enable_o,
    output logic             up_read_burst_enable_o,
    // Interrupt
    output logic             irq_o
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [31:0] ctl_q;      // Writable fields plus flag
    logic [1:0]  stat_q;     // Sticky events
    logic [1:0]  mask_q;     // Event mask
    logic        req_go;     // Access taken this cycle
    logic        wr_go;      // Write taken this cycle
    logic [31:0] wmask;      // Byte lane mask
    logic        sys_hit;
    logic        stat_hit;
    logic        mask_hit;
    logic        pwr_ev;     // Enabled power write
    logic [1:0]  ev;

    // ------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------
    // A request is taken only while ack is low, so a master that holds
    // its strobe through the ack cycle is not served twice.
    // Decode compares the full byte address; the low two bits must be
    // zero, so a misaligned access falls into the unmapped branch.
    // Events are qualified by their enables here, once, so the flag,
    // the status register and the pulse outputs all agree.
    assign req_go   = ce_i && cyc_i && stb_i && !ack_o;
    assign wr_go    = req_go && we_i;
    assign wmask    = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign sys_hit  = (adr_i == SYSCTL_OFFSET);
    assign stat_hit = (adr_i == IRQ_STAT_OFFSET);
    assign mask_hit = (adr_i == IRQ_MASK_OFFSET);
    assign pwr_ev   = power_write_i && ctl_q[PIRQ_EN_BIT];
    assign ev       = {card_dma_req_i && ctl_q[DREQ_EN_BIT], pwr_ev};

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    // Writable bits take the masked write; reserved bits never store
    // The flag bit is excluded from the plain store: it only clears
    // on a written one and only sets on an event, and the event wins.
    // Bits 13..0 keep their reset pattern but are masked on read.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_q <= SYSCTL_RESET;
        end else if (ce_i) begin
            if (wr_go && sys_hit) begin
                ctl_q <= (ctl_q & ~(SYSCTL_WMASK & wmask)) | (dat_i & SYSCTL_WMASK & wmask);
            end
            // Flag: write-one clear, but a new event wins
            if (wr_go && sys_hit && sel_i[3] && dat_i[FLAG_BIT]) begin
                ctl_q[FLAG_BIT] <= 1'b0;
            end else begin
                ctl_q[FLAG_BIT] <= ctl_q[FLAG_BIT];
            end
            if (pwr_ev) begin
                ctl_q[FLAG_BIT] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    // Status bits are sticky and cleared by a written one in lane 0.
    // An event in the same cycle as the clear keeps its bit set, so
    // no event is ever lost to a racing software clear.
    // The mask simply stores the low two bits of lane 0.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= IRQ_RESET;
            mask_q <= IRQ_RESET;
        end else if (ce_i) begin
            if (wr_go && stat_hit && sel_i[0]) begin
                stat_q <= (stat_q & ~dat_i[1:0]) | ev; // Set beats clear
            end else begin
                stat_q <= stat_q | ev;
            end
            if (wr_go && mask_hit && sel_i[0]) begin
                mask_q <= dat_i[1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Bus answer: one wait cycle, ack one cycle
    // ------------------------------------------------------------------
    // Read data is registered with the ack, so it stands in the cycle in
    // which the master samples ack high and holds until the next read.
    // Trade-off: one cycle of latency buys a clean flop-driven output.
    // Unmapped addresses answer too, so a stray access never hangs.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_o <= req_go;
            if (req_go && !we_i) begin
                if (sys_hit) begin
                    dat_o <= ctl_q & SYSCTL_WMASK;
                end else if (stat_hit) begin
                    dat_o <= {30'h0000_0000, stat_q};
                end else if (mask_hit) begin
                    dat_o <= {30'h0000_0000, mask_q};
                end else begin
                    dat_o <= 32'h0000_0000; // Unmapped reads zero
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Registered control outputs
    // ------------------------------------------------------------------
    // Power signalling pulses one cycle after the enabled write
    // Every output comes from a flop and lags its field by one cycle.
    // The reserved pins are only ever driven low; the enable alone
    // decides between low and high impedance.
    // The supply protection output is active high, the inverse of bit 21.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_serial_slot_step_o   <= 2'h0;
            internal_osc_enable_o    <= 1'b0;
            power_irq2_o             <= 1'b0;
            card_status_change_o     <= 1'b0;
            reserved_pin_drive_low_o <= 1'b0;
            reserved_pin_oe_o        <= 1'b0;
            supply_protect_enable_o  <= 1'b1;
            upper_addr_float_o       <= 1'b0;
            dma_request_o            <= 1'b0;
            dma_channel_select_o     <= CHAN_UNUSED;
            down_read_burst_enable_o <= 1'b1;
            up_read_burst_enable_o   <= 1'b0;
            irq_o                    <= 1'b0;
        end else if (ce_i) begin
            irq_serial_slot_step_o   <= ctl_q[STEP_LSB +: 2];
            internal_osc_enable_o    <= ctl_q[OSC_BIT];
            power_irq2_o             <= pwr_ev && !ctl_q[ROUTE_BIT];
            card_status_change_o     <= pwr_ev && ctl_q[ROUTE_BIT];
            reserved_pin_drive_low_o <= 1'b0;
            reserved_pin_oe_o        <= cardbus_present_i && ctl_q[RSVD_DRV_BIT];
            supply_protect_enable_o  <= !ctl_q[PROT_BIT];
            upper_addr_float_o       <= ctl_q[RZV_BIT];
            dma_request_o            <= card_dma_req_i && ctl_q[DREQ_EN_BIT];
            dma_channel_select_o     <= ctl_q[CHAN_LSB +: 3];
            down_read_burst_enable_o <= ctl_q[BURST_DN_BIT];
            up_read_burst_enable_o   <= ctl_q[BURST_UP_BIT];
            irq_o                    <= |(stat_q & mask_q);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // The checks below watch the stored word and the registered outputs.
    // Most output checks compare with the field one cycle earlier, which
    // matches the one-cycle lag of every output flop.
    // Checks that start on an enabled cycle read the result at the next
    // edge; a frozen cycle in between leaves that result standing.
    // Reset disables every check, so the reset values are checked from
    // the bench instead.

    flag_set_a: assert property (ce_i && pwr_ev |=> ctl_q[FLAG_BIT])
        else $error("power flag not set");
    flag_clr_a: assert property (ce_i && wr_go && sys_hit && sel_i[3] && dat_i[FLAG_BIT] && !pwr_ev
        |=> !ctl_q[FLAG_BIT])
        else $error("power flag not cleared");
    flag_keep_a: assert property (ce_i && wr_go && sys_hit && !dat_i[FLAG_BIT] && $past(1'b1)
        && ctl_q[FLAG_BIT] |=> ctl_q[FLAG_BIT])
        else $error("power flag lost");
    rsvd_zero_a: assert property (ack_o && $past(sys_hit) && !$past(we_i)
        |-> dat_o[29:28] == 2'h0 && !dat_o[23])
        else $error("reserved bits nonzero");
    route_a: assert property (ce_i && pwr_ev && !ctl_q[ROUTE_BIT] |=> power_irq2_o && !card_status_change_o)
        else $error("power irq misrouted");
    osc_a: assert property (ce_i |=> internal_osc_enable_o == $past(ctl_q[OSC_BIT]))
        else $error("oscillator enable mismatch");
    dma_a: assert property (ce_i && !ctl_q[DREQ_EN_BIT] |=> !dma_request_o)
        else $error("dma request not gated");
    rsvd_pin_a: assert property (ce_i && !cardbus_present_i |=> !reserved_pin_oe_o)
        else $error("reserved pins driven without card");
    readback_a: assert property (ce_i && wr_go && sys_hit && sel_i == 4'hF
        |=> (ctl_q[31:26] & 6'h33) == ($past(dat_i[31:26]) & 6'h33))
        else $error("write not stored");
    ack_a: assert property (ce_i && req_go |=> ack_o ##1 !ack_o || !ce_i)
        else $error("ack not one cycle");

    // Slot step output follows its field
    // A wrong slot would steer the first interrupt line elsewhere
    step_a: assert property (ce_i |=> irq_serial_slot_step_o == $past(ctl_q[STEP_LSB +: 2]))
        else $error("slot step mismatch");

    // Protection output is the inverse of bit 21
    // Clear bit means protection on, the safe default
    prot_a: assert property (ce_i |=> supply_protect_enable_o == !$past(ctl_q[PROT_BIT]))
        else $error("supply protection mismatch");

    // Upper address float follows reduced video
    // Floating these lines breaks ordinary video mode
    float_a: assert property (ce_i |=> upper_addr_float_o == $past(ctl_q[RZV_BIT]))
        else $error("address float mismatch");

    // Channel output follows the channel field
    // Code four means unused and is the reset value
    chan_a: assert property (ce_i |=> dma_channel_select_o == $past(ctl_q[CHAN_LSB +: 3]))
        else $error("dma channel mismatch");

    // Downstream burst enable follows bit 15
    // A stuck enable would either burst or throttle all reads
    burst_dn_a: assert property (ce_i |=> down_read_burst_enable_o == $past(ctl_q[BURST_DN_BIT]))
        else $error("downstream burst mismatch");

    // Upstream burst enable follows bit 14
    // Upstream bursting is off until software asks for it
    burst_up_a: assert property (ce_i |=> up_read_burst_enable_o == $past(ctl_q[BURST_UP_BIT]))
        else $error("upstream burst mismatch");

    // Reserved bits 29, 28 and 23 never hold a one
    // They are outside the write mask, so no write can reach them
    rsvd_store_a: assert property (ctl_q[29:28] == 2'h0 && !ctl_q[23])
        else $error("reserved bits stored");

    // Status-change route when bit 26 is set
    // The other route must stay quiet in that case
    csc_route_a: assert property (ce_i && pwr_ev && ctl_q[ROUTE_BIT] |=> card_status_change_o && !power_irq2_o)
        else $error("status change misrouted");

    // No power interrupt without an enabled power write
    // Guards against pulses while the enable is clear
    pwr_quiet_a: assert property (ce_i && !pwr_ev |=> !power_irq2_o && !card_status_change_o)
        else $error("spurious power interrupt");

    // Flag never sets without an enabled event
    // A write of one to the flag must not set it
    flag_hold_a: assert property (ce_i && !pwr_ev && !ctl_q[FLAG_BIT] |=> !ctl_q[FLAG_BIT])
        else $error("power flag set without event");

    // Card requests pass while enabled
    // Complements the gating check for the enabled case
    dma_pass_a: assert property (ce_i && card_dma_req_i && ctl_q[DREQ_EN_BIT] |=> dma_request_o)
        else $error("dma request dropped");

    // Reserved pins driven low with a card and bit 22
    // The pin value is always low; only the enable moves
    pin_drive_a: assert property (ce_i && cardbus_present_i && ctl_q[RSVD_DRV_BIT]
        |=> reserved_pin_oe_o && !reserved_pin_drive_low_o)
        else $error("reserved pins not driven");

    // Interrupt level follows unmasked status
    // One cycle of lag from the status flops to the pin
    irq_level_a: assert property (ce_i |=> irq_o == |$past(stat_q & mask_q))
        else $error("interrupt level mismatch");

    // Status bit stays set until cleared by software
    // Sticky bits must survive reads and writes of other places
    stat_keep_a: assert property (ce_i && stat_q[0] && !(wr_go && stat_hit && sel_i[0] && dat_i[0])
        |=> stat_q[0])
        else $error("status bit lost");

    // Status bit clears on a written one without an event
    // The event case is left to the set-wins rule
    stat_clr_a: assert property (ce_i && wr_go && stat_hit && sel_i[0] && dat_i[0] && !ev[0] |=> !stat_q[0])
        else $error("status bit not cleared");

    // Mask stores lane 0
    // The mask has the same layout as the status register
    mask_store_a: assert property (ce_i && wr_go && mask_hit && sel_i[0] |=> mask_q == $past(dat_i[1:0]))
        else $error("mask not stored");

    // No ack without a taken request
    // A stray ack would end a later cycle too early
    ack_only_a: assert property (ce_i && !req_go |=> !ack_o)
        else $error("ack without request");

    // Clock enable low freezes state
    // Holds the word, the status and the bus answer
    freeze_a: assert property (!ce_i |=> $stable(ctl_q) && $stable(stat_q) && $stable(ack_o))
        else $error("state moved while frozen");

    pwr_c:  cover property (pwr_ev ##1 ctl_q[FLAG_BIT]);
    irq_c:  cover property (irq_o);
    rd_c:   cover property (ack_o && !we_i && sys_hit);
    clr_c:  cover property (ctl_q[FLAG_BIT] ##[1:20] !ctl_q[FLAG_BIT]);
    csc_c:  cover property (card_status_change_o);

endmodule : card_bridge_system_control

// *** src/sysctl_pkg.sv ***
package sysctl_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  SYSCTL_OFFSET = 8'h80;   // System control word
    localparam logic [7:0]  IRQ_STAT_OFFSET = 8'h84; // Sticky event status
    localparam logic [7:0]  IRQ_MASK_OFFSET = 8'h88; // Event mask

    // ------------------------------------------------------------------
    // Field positions in the system control word
    // ------------------------------------------------------------------
    localparam int STEP_LSB     = 30;
    localparam int OSC_BIT      = 27;
    localparam int ROUTE_BIT    = 26;
    localparam int FLAG_BIT     = 25;
    localparam int PIRQ_EN_BIT  = 24;
    localparam int RSVD_DRV_BIT = 22;
    localparam int PROT_BIT     = 21;
    localparam int RZV_BIT      = 20;
    localparam int DREQ_EN_BIT  = 19;
    localparam int CHAN_LSB     = 16;
    localparam int BURST_DN_BIT = 15;
    localparam int BURST_UP_BIT = 14;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] SYSCTL_RESET = 32'h0044_9060;
    localparam logic [31:0] SYSCTL_WMASK = 32'hCF7F_C000; // Writable bits 31..14 except 29, 28 and 23
    localparam logic [2:0]  CHAN_UNUSED  = 3'h4;
    localparam logic [1:0]  IRQ_RESET    = 2'h0;

    // Event bits in status and mask
    localparam int EV_PWR_WRITE = 0; // Power write seen while enabled
    localparam int EV_DMA_REQ   = 1; // Card DMA request accepted

endpackage : sysctl_pkg

// *** verif/card_bridge_system_control_tb.sv ***
`timescale 1ns/1ps
module card_bridge_system_control_tb;
    import sysctl_pkg::*;
    // ------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------
    logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000, dat_o, q;
    logic ack_o, irq_o, irq2, card_status_change, oe, drv_lo, prot, flt, dma, dn, up, osc;
    logic pw = 1'b0, dreq = 1'b0, present = 1'b0;
    logic [1:0] step;
    logic [2:0] chan;
    int fails = 0, n_tests = 0, n2, nc;
    // ------------------------------------------------------------------
    // Device under test and clock
    // ------------------------------------------------------------------
    card_bridge_system_control dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .power_write_i(pw), .card_dma_req_i(dreq), .cardbus_present_i(present),
        .irq_serial_slot_step_o(step), .internal_osc_enable_o(osc), .power_irq2_o(irq2),
        .card_status_change_o(card_status_change), .reserved_pin_drive_low_o(drv_lo), .reserved_pin_oe_o(oe),
        .supply_protect_enable_o(prot), .upper_addr_float_o(flt), .dma_request_o(dma),
        .dma_channel_select_o(chan), .down_read_burst_enable_o(dn), .up_read_burst_enable_o(up), .irq_o(irq_o));
    always #2.5 clk_i = ~clk_i;
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Compare a seen value with the expected one
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One classic Wishbone cycle; waits for ack, then leaves the bus idle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) chk(1'b0, 1'b1);
        q = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : wb
    // One socket power write; counts the interrupt pulses that follow
    task automatic pulse();
        n2 = 0;
        nc = 0;
        pw <= 1'b1;
        @(posedge clk_i);
        pw <= 1'b0;
        repeat (4) begin
            @(posedge clk_i);
            n2 += (irq2 === 1'b1);
            nc += (card_status_change === 1'b1);
        end
    endtask : pulse
    // Verdict, reached from the main sequence or the watchdog
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run
    // Watchdog; the sequence needs well under 2000 cycles
    initial begin
        #100000;
        fails++;
        complete_run();
    end
    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, SYSCTL_OFFSET, 32'h0, 4'hF); chk(q, 32'h0044_8000);
        chk({osc, prot, chan, dn, up, oe}, {1'b0, 1'b1, 3'h4, 1'b1, 1'b0, 1'b0});
        present <= 1'b1;
        wb(1'b1, SYSCTL_OFFSET, 32'hFFFF_FFFF, 4'hF);
        wb(1'b0, SYSCTL_OFFSET, 32'h0, 4'hF); chk(q, 32'hCD7F_C000);
        chk({step, osc, prot, flt, chan, up, dn}, {2'h3, 1'b1, 1'b0, 1'b1, 3'h7, 1'b1, 1'b1});
        chk({oe, drv_lo}, 2'b10);
        wb(1'b1, SYSCTL_OFFSET, 32'h0, 4'hF);
        wb(1'b0, SYSCTL_OFFSET, 32'h0, 4'hF); chk(q, 32'h0);
        chk({oe, dn, flt, prot}, 4'b0001);
        // Every step and every channel code
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, SYSCTL_OFFSET, (32'(i % 4) << 30) | (32'(i) << 16), 4'hF);
            chk({step, chan}, {2'(i % 4), 3'(i)});
        end
        // Card DMA requests pass only while enabled
        dreq <= 1'b1;
        wb(1'b1, SYSCTL_OFFSET, 32'h0008_0000, 4'hF); chk(dma, 1'b1);
        wb(1'b1, SYSCTL_OFFSET, 32'h0, 4'hF); chk(dma, 1'b0);
        dreq <= 1'b0;
        wb(1'b1, IRQ_STAT_OFFSET, 32'hFFFF_FFFF, 4'hF);
        // Power write events through both routes: irq2 route unmasked, status-change route masked
        for (int r = 0; r < 2; r++) begin
            wb(1'b1, IRQ_MASK_OFFSET, 32'(r == 0), 4'hF);
            wb(1'b1, SYSCTL_OFFSET, 32'h0100_0000 | (32'(r) << 26), 4'hF);
            pulse();
            chk({n2 > 0, nc > 0}, {r == 0, r == 1});
            chk(irq_o, 1'(r == 0));
            wb(1'b0, SYSCTL_OFFSET, 32'h0, 4'hF); chk(q, 32'h0300_0000 | (32'(r) << 26));
            wb(1'b1, SYSCTL_OFFSET, 32'h0100_0000 | (32'(r) << 26), 4'hF);
            wb(1'b0, SYSCTL_OFFSET, 32'h0, 4'hF); chk(q[25], 1'b1);
            wb(1'b1, SYSCTL_OFFSET, 32'h0300_0000 | (32'(r) << 26), 4'hF);
            wb(1'b0, SYSCTL_OFFSET, 32'h0, 4'hF); chk(q[25], 1'b0);
            wb(1'b0, IRQ_STAT_OFFSET, 32'h0, 4'hF); chk(q, 32'h1);
            wb(1'b1, IRQ_STAT_OFFSET, 32'h1, 4'hF); chk(irq_o, 1'b0);
        end
        // No event while the enable is clear
        wb(1'b1, SYSCTL_OFFSET, 32'h0, 4'hF);
        pulse();
        chk({n2 > 0, nc > 0}, 2'b00);
        wb(1'b0, SYSCTL_OFFSET, 32'h0, 4'hF); chk(q, 32'h0);
        // Unmapped place reads zero and ignores writes
        wb(1'b1, 8'h90, 32'hFFFF_FFFF, 4'hF);
        wb(1'b0, 8'h90, 32'h0, 4'hF); chk(q, 32'h0);
        wb(1'b0, SYSCTL_OFFSET, 32'h0, 4'hF); chk(q, 32'h0);
        complete_run();
    end
endmodule : card_bridge_system_control_tb
